/* File: rtl/lcce_pkg.sv */
// Purpose: Shared constants and types for the loop and CPU control execution block.
// Assumes: Registers are 32-bit words on a classic Wishbone slave.
// Notes: Offsets are byte addresses.
package lcce_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_PC = 8'h04;
	localparam logic [7:0] ADDR_DISP = 8'h08;
	localparam logic [7:0] ADDR_DST = 8'h0C;
	localparam logic [7:0] ADDR_PSW = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int OP_LSB = 0;
	localparam int IMM_LSB = 8;
	localparam int INV_LSB = 16;
	localparam int LEN_LSB = 24;
	localparam int PSW_CY = 0;
	localparam int PSW_AC = 4;
	localparam int PSW_Z = 6;
	localparam int STAT_BANK_LSB = 8;
	localparam int STAT_IE = 10;
	localparam int STAT_SHADOW = 11;
	localparam int STAT_BUSY = 12;
	localparam int STAT_TAKEN = 13;
	localparam int STAT_REJECT = 14;
	localparam int STAT_STOP = 15;
	// ****************************************************************
	// Reset values and codes
	// ****************************************************************
	localparam logic [31:0] INSTR_RST = 32'h0000_0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] STANDBY_CONTROL_REG_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'hF;
	localparam logic [7:0] STANDBY_CONTROL_REG_STOP = 8'h02;
	typedef enum logic [2:0] {
		OP_IDLE = 3'h0,
		OP_LOOP = 3'h1,
		OP_STANDBY_CONTROL_REG = 3'h2,
		OP_BANK = 3'h3,
		OP_EI = 3'h4,
		OP_DI = 3'h5
	} lcce_op_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DECR = 2'b01,
		ST_BRANCH = 2'b10
	} lcce_state_type;
endpackage

/* File: rtl/lcce_reg_if.sv */
// Purpose: Register access path between the bus slave and the execution core.
// Assumes: One clock domain.
// Notes: rdata is combinational from the core and registered by the slave.
`timescale 1ns/1ps
`default_nettype none
interface lcce_reg_if;
	logic wrStrobe;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] wrMask;
	logic [31:0] rdata;
	modport slave (output wrStrobe, output addr, output wdata, output wrMask, input rdata);
	modport core (input wrStrobe, input addr, input wdata, input wrMask, output rdata);
endinterface
`default_nettype wire

/* File: rtl/lcce_wb_slave.sv */
// Purpose: Classic Wishbone slave front end with one wait state.
// Assumes: Master holds the request until it samples ack high.
// Notes: Writes take effect at the edge where ack is high.
`timescale 1ns/1ps
`default_nettype none
module lcce_wb_slave
	import lcce_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Core side
	lcce_reg_if.slave bus
);
	wire reqNew = cyc_i & stb_i & ~ack_o;

	assign bus.wrStrobe = cyc_i & stb_i & we_i & ack_o;
	assign bus.addr = adr_i;
	assign bus.wdata = dat_i;

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : gLane
			assign bus.wrMask[lane*8 +: 8] = {8{sel_i[lane]}};
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= reqNew;
			dat_o <= (reqNew & ~we_i) ? bus.rdata : 32'h0000_0000;
		end
	end
endmodule // lcce_wb_slave
`default_nettype wire

/* File: rtl/lcce_irq_gate.sv */
// Purpose: Interrupt and macro service acknowledgment gate.
// Assumes: Requesters drop their request after seeing the ack pulse.
// Notes: Lowest source index wins; one idle cycle follows every ack.
`timescale 1ns/1ps
`default_nettype none
module lcce_irq_gate (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests and gating
	input wire logic [3:0] irqReq,
	input wire logic [3:0] irqMask,
	input wire logic msReq,
	input wire logic irqEnable,
	input wire logic blocked,
	// Acknowledgments
	output logic [3:0] irqAck,
	output logic msAck
);
	wire [3:0] cand = irqReq & ~irqMask & {4{irqEnable}};
	wire [3:0] grant;
	wire hold = blocked | (|irqAck) | msAck;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : gPri
			if (i == 0) begin : gFirst
				assign grant[i] = cand[i];
			end else begin : gRest
				assign grant[i] = cand[i] & ~(|cand[i-1:0]);
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqAck <= 4'h0;
			msAck <= 1'b0;
		end else begin
			irqAck <= hold ? 4'h0 : grant;
			msAck <= ~hold & msReq & ~(|cand);
		end
	end
endmodule // lcce_irq_gate
`default_nettype wire

/* File: rtl/lcce_top.sv */
// Purpose: Executes the loop instruction and the CPU control instructions.
// Assumes: Decode writes the instruction word; PC, displacement and operand are loaded first.
// Notes: Loop takes three cycles, all other instructions complete at issue.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lcce_top
	import lcce_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Interrupt side
	input wire logic [3:0] irqReq,
	input wire logic msReq,
	output logic [3:0] irqAck,
	output logic msAck,
	// Core state
	output logic irqEnable,
	output logic [1:0] bankSel,
	output logic stopMode
);
	// ****************************************************************
	// Bus slave
	// ****************************************************************
	lcce_reg_if regBus ();

	lcce_wb_slave uSlave (
		.clk(clk),
		.rst_n(rst_n),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.bus(regBus.slave)
	);

	// ****************************************************************
	// State
	// ****************************************************************
	lcce_state_type state;
	lcce_state_type next_state;
	logic [31:0] instr;
	logic [15:0] pc;
	logic [15:0] disp;
	logic [7:0] dst;
	logic [7:0] program_status_word;
	logic [3:0] irqMask;
	logic [7:0] standby_control_reg;
	logic shadow;
	logic taken;
	logic reject;

	function automatic logic [31:0] mergeW(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] mask);
		mergeW = (old & ~mask) | (nw & mask);
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire idle = (state == ST_IDLE);
	wire wr = regBus.wrStrobe;
	wire [31:0] mergedData;
	wire [31:0] newInstr;
	wire [2:0] newOpCode;
	wire [7:0] newImm;
	wire [7:0] newInv;
	wire [15:0] newLen;
	wire [15:0] curLen;
	wire issue;
	wire isLoop;
	wire isStbc;
	wire isBank;
	wire isEi;
	wire isDi;
	wire stbcMatch;
	wire stbcWrite;
	wire done;
	wire [15:0] pcSeq;
	wire [15:0] pcTarget;

	assign mergedData = mergeW(32'h0000_0000, regBus.wdata, regBus.wrMask);
	assign newInstr = mergeW(instr, regBus.wdata, regBus.wrMask);
	assign newOpCode = newInstr[OP_LSB +: 3];
	assign newImm = newInstr[IMM_LSB +: 8];
	assign newInv = newInstr[INV_LSB +: 8];
	assign newLen = {13'h0000, newInstr[LEN_LSB +: 3]};
	assign curLen = {13'h0000, instr[LEN_LSB +: 3]};

	// A new instruction is only taken while the loop sequence is idle.
	assign issue = wr && (regBus.addr == ADDR_INSTR) && idle;
	assign isLoop = issue && (newOpCode == OP_LOOP);
	assign isStbc = issue && (newOpCode == OP_STANDBY_CONTROL_REG);
	assign isBank = issue && (newOpCode == OP_BANK);
	assign isEi = issue && (newOpCode == OP_EI);
	assign isDi = issue && (newOpCode == OP_DI);

	assign stbcMatch = (newInv == ~newImm);
	assign stbcWrite = isStbc && stbcMatch;

	// Every instruction except the loop completes at its issue edge.
	assign done = (issue && !isLoop) || (state == ST_BRANCH);

	assign pcSeq = pc + curLen;
	assign pcTarget = pcSeq + disp;

	wire wrPc = wr && (regBus.addr == ADDR_PC) && idle;
	wire wrDisp = wr && (regBus.addr == ADDR_DISP) && idle;
	wire wrDst = wr && (regBus.addr == ADDR_DST) && idle;
	wire wrPsw = wr && (regBus.addr == ADDR_PSW) && idle;
	wire wrMask = wr && (regBus.addr == ADDR_MASK);

	// ****************************************************************
	// Next values
	// ****************************************************************
	wire [7:0] next_dst;
	wire [15:0] next_pc;
	wire [15:0] next_disp;
	wire [7:0] next_psw;
	wire next_shadow;
	wire next_ie;
	wire [31:0] dstMerge;
	wire [31:0] pcMerge;
	wire [31:0] dispMerge;
	wire [31:0] pswMerge;

	assign dstMerge = mergeW({24'h000000, dst}, regBus.wdata, regBus.wrMask);
	assign pcMerge = mergeW({16'h0000, pc}, regBus.wdata, regBus.wrMask);
	assign dispMerge = mergeW({16'h0000, disp}, regBus.wdata, regBus.wrMask);
	assign pswMerge = mergeW({24'h000000, program_status_word}, regBus.wdata, regBus.wrMask);

	assign next_dst = (state == ST_DECR) ? dst - 8'h01
		: wrDst ? dstMerge[7:0]
		: dst;

	assign next_pc = (state == ST_BRANCH) ? ((dst != 8'h00) ? pcTarget : pcSeq)
		: (issue && !isLoop) ? pc + newLen
		: wrPc ? pcMerge[15:0]
		: pc;

	assign next_disp = wrDisp ? dispMerge[15:0]
		: disp;

	// Flags move only on a software write, never during execution.
	assign next_psw = wrPsw ? pswMerge[7:0]
		: program_status_word;

	assign next_shadow = (isEi || isDi) ? 1'b1 : done ? 1'b0 : shadow;

	assign next_ie = isEi ? 1'b1
		: isDi ? 1'b0
		: irqEnable;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (isLoop) begin
					next_state = ST_DECR;
				end
			end
			ST_DECR: begin
				next_state = ST_BRANCH;
			end
			ST_BRANCH: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			instr <= INSTR_RST;
			pc <= PC_RST;
			disp <= 16'h0000;
			dst <= 8'h00;
		end else begin
			state <= next_state;
			instr <= issue ? newInstr : instr;
			pc <= next_pc;
			disp <= next_disp;
			dst <= next_dst;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			program_status_word <= PSW_RST;
			irqMask <= MASK_RST;
			shadow <= 1'b0;
			irqEnable <= 1'b0;
		end else begin
			program_status_word <= next_psw;
			irqMask <= wrMask ? mergedData[3:0] : irqMask;
			shadow <= next_shadow;
			irqEnable <= next_ie;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_control_reg <= STANDBY_CONTROL_REG_RST;
			stopMode <= 1'b0;
			reject <= 1'b0;
		end else begin
			standby_control_reg <= stbcWrite ? newImm : standby_control_reg;
			stopMode <= stbcWrite ? (newImm == STANDBY_CONTROL_REG_STOP) : stopMode;
			reject <= isStbc ? !stbcMatch : reject;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bankSel <= 2'b00;
			taken <= 1'b0;
		end else begin
			bankSel <= isBank ? newImm[1:0] : bankSel;
			taken <= (state == ST_BRANCH) ? (dst != 8'h00) : taken;
		end
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	wire [31:0] statWord;

	// Standby control is visible here but has no bus write path.
	assign statWord = {16'h0000, stopMode, reject, taken, !idle, shadow, irqEnable,
		bankSel, standby_control_reg};

	assign regBus.rdata = (regBus.addr == ADDR_INSTR) ? instr
		: (regBus.addr == ADDR_PC) ? {16'h0000, pc}
		: (regBus.addr == ADDR_DISP) ? {16'h0000, disp}
		: (regBus.addr == ADDR_DST) ? {24'h000000, dst}
		: (regBus.addr == ADDR_PSW) ? {24'h000000, program_status_word}
		: (regBus.addr == ADDR_MASK) ? {28'h0000000, irqMask}
		: (regBus.addr == ADDR_STAT) ? statWord
		: 32'h0000_0000;

	// ****************************************************************
	// Interrupt gate
	// ****************************************************************
	lcce_irq_gate uGate (
		.clk(clk),
		.rst_n(rst_n),
		.irqReq(irqReq),
		.irqMask(irqMask),
		.msReq(msReq),
		.irqEnable(irqEnable),
		.blocked(shadow || !idle),
		.irqAck(irqAck),
		.msAck(msAck)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence loopStart;
		isLoop;
	endsequence

	sequence loopRun;
		(state == ST_DECR) ##1 (state == ST_BRANCH) ##1 (state == ST_IDLE);
	endsequence

	loop_walk_a: assert property (loopStart |=> loopRun)
		else $error("loop sequence did not run decrement then branch");

	loop_decr_a: assert property ((state == ST_DECR) |=> dst == $past(dst) - 8'h01)
		else $error("loop did not write back the decremented operand");

	loop_taken_a: assert property ((state == ST_BRANCH) && (dst != 8'h00) |=>
		pc == $past(pc) + $past(curLen) + $past(disp))
		else $error("taken loop branch went to the wrong target");

	loop_fall_a: assert property ((state == ST_BRANCH) && (dst == 8'h00) |=>
		pc == $past(pc) + $past(curLen) && !taken)
		else $error("loop at zero did not fall through");

	flags_keep_a: assert property (loopStart |=> $stable(program_status_word) [*3])
		else $error("flags changed during loop");

	standby_control_reg_guard_a: assert property (!$stable(standby_control_reg) |-> $past(isStbc && stbcMatch))
		else $error("standby control changed outside guarded write");

	standby_control_reg_reject_a: assert property (isStbc && !stbcMatch |=> $stable(standby_control_reg) && reject)
		else $error("mismatched standby write was not suppressed");

	stop_mode_a: assert property (stbcWrite && (newImm == STANDBY_CONTROL_REG_STOP) |=>
		stopMode && standby_control_reg == STANDBY_CONTROL_REG_STOP)
		else $error("writing two did not enter stop mode");

	bank_load_a: assert property (isBank |=> bankSel == $past(newImm[1:0]))
		else $error("bank select did not load");

	idle_instr_a: assert property (issue && (newOpCode == OP_IDLE) |=>
		pc == $past(pc) + $past(newLen) && $stable(dst) && $stable(standby_control_reg))
		else $error("idle instruction changed state");

	ie_set_a: assert property (isEi |=> irqEnable && shadow)
		else $error("enable instruction did not set the flag");

	ie_clear_a: assert property (isDi |=> !irqEnable && shadow)
		else $error("disable instruction did not clear the flag");

	ack_shadow_a: assert property (shadow |=> (irqAck == 4'h0) && !msAck)
		else $error("acknowledge during the enable shadow");

	mask_keep_a: assert property ((irqAck != 4'h0) |->
		$past(irqEnable) && (($past(irqMask) & irqAck) == 4'h0))
		else $error("masked or disabled source was acknowledged");

	bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus ack not a single cycle after request");
endmodule // lcce_top
`default_nettype wire

/* File: bench/lcce_top_tb.sv */
// Purpose: Self-checking bench for the loop and CPU control execution block.
// Assumes: Registers are reached over classic Wishbone; one clock at 40 MHz.
// Notes: Ordinary instructions run from a table; reset and bus refusals come before it, interrupts follow it.
`timescale 1ns/1ps
`default_nettype none
module lcce_top_tb
	import lcce_pkg::*;
;
	// ****************************************************************
	// Signals and instance
	// ****************************************************************
	localparam int LIMIT = 20000;
	typedef struct {
		logic [31:0] instr;
		logic [15:0] pc0;
		logic [15:0] disp;
		logic [7:0] dst0;
		logic [15:0] expPc;
		logic [7:0] expDst;
		logic [15:0] expStat;
		logic [15:0] statMask;
	} lcce_row_type;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cycI = 1'b0;
	logic stbI = 1'b0;
	logic weI = 1'b0;
	logic [7:0] adrI = 8'h00;
	logic [3:0] selI = 4'h0;
	logic [31:0] datI = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [3:0] irqReq = 4'h0;
	logic msReq = 1'b0;
	logic [3:0] irqAck;
	logic msAck;
	logic irqEnable;
	logic [1:0] bankSel;
	logic stopMode;
	logic [4:0] lastAck = 5'h00;
	logic [31:0] rd;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int ackCount = 0;
	int ackBase = 0;
	lcce_row_type rows [15];
	lcce_top dut (.clk(clk), .rst_n(rst_n), .cyc_i(cycI), .stb_i(stbI), .we_i(weI),
		.adr_i(adrI), .sel_i(selI), .dat_i(datI), .dat_o(dat_o), .ack_o(ack_o),
		.irqReq(irqReq), .msReq(msReq), .irqAck(irqAck), .msAck(msAck),
		.irqEnable(irqEnable), .bankSel(bankSel), .stopMode(stopMode));
	always #12.5 clk = ~clk;
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic summarize();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic checkWord(input string what, input logic [31:0] expv, input logic [31:0] got);
		comparisons++;
		if (got !== expv) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, expv, got);
		end
	endtask
	task automatic wbCycle(input logic wr, input logic [7:0] adr, input logic [31:0] wdat,
			output logic [31:0] rdat);
		int n;
		@(posedge clk);
		cycI <= 1'b1;
		stbI <= 1'b1;
		weI <= wr;
		adrI <= adr;
		selI <= 4'hF;
		datI <= wdat;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (ack_o !== 1'b1) begin
			fails++;
			$display("CHECK FAILED bus ack expected 1 seen %b", ack_o);
		end
		rdat = dat_o;
		cycI <= 1'b0;
		stbI <= 1'b0;
		weI <= 1'b0;
	endtask
	// Busy is polled so that no instruction is written while a loop still runs.
	task automatic execInstr(input logic [31:0] instr);
		logic [31:0] st;
		int n;
		wbCycle(1'b1, ADDR_INSTR, instr, st);
		n = 0;
		do begin
			wbCycle(1'b0, ADDR_STAT, 32'h0, st);
			n++;
		end while (st[STAT_BUSY] !== 1'b0 && n < 20);
	endtask
	task automatic noAck(input int n);
		int base;
		base = ackCount;
		repeat (n) @(posedge clk);
		checkWord("ack count", 32'(base), 32'(ackCount));
	endtask
	// The base is taken before the instruction that opens the gate, so an early ack counts.
	task automatic waitAck(input int base, input logic [4:0] expv);
		int n;
		n = 0;
		while (ackCount == base && n < 12) begin
			@(posedge clk);
			n++;
		end
		checkWord("ack seen", 32'(base + 1), 32'(ackCount));
		checkWord("ack value", {27'h0, expv}, {27'h0, lastAck});
	endtask
	// ****************************************************************
	// Monitor and timeout
	// ****************************************************************
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (irqAck !== 4'h0 || msAck !== 1'b0) begin
			ackCount <= ackCount + 1;
			lastAck <= {msAck, irqAck};
			// A requester drops its request once it has been acknowledged.
			irqReq <= irqReq & ~irqAck;
			msReq <= msReq & ~msAck;
		end
		if (cycles == LIMIT) begin
			fails++;
			summarize();
		end
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		// Columns: instr, pc0, disp, dst0, expPc, expDst, expStat, statMask.
		// Standby rows carry the inverted immediate in bits 23:16, except the rejected row, which carries 00 there.
		rows = '{
			'{32'h0200_0001, 16'h0100, 16'h0010, 8'h05, 16'h0112, 8'h04, 16'h2000, 16'hAFFF},
			'{32'h0300_0001, 16'h0100, 16'hFFFC, 8'h01, 16'h0103, 8'h00, 16'h0000, 16'hAFFF},
			'{32'h0200_0001, 16'h0100, 16'hFFF0, 8'h00, 16'h00F2, 8'hFF, 16'h2000, 16'hAFFF},
			'{32'h0200_0001, 16'hFFFE, 16'h0004, 8'h02, 16'h0004, 8'h01, 16'h2000, 16'hAFFF},
			'{32'h01FD_0202, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h8002, 16'hCFFF},
			'{32'h0100_0202, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'hC002, 16'hCFFF},
			'{32'h01FF_0002, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0000, 16'hCFFF},
			'{32'h0100_0303, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0300, 16'h8FFF},
			'{32'h0100_0103, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0100, 16'h8FFF},
			'{32'h0100_0203, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0200, 16'h8FFF},
			'{32'h0100_0003, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0000, 16'h8FFF},
			'{32'h0100_0004, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0C00, 16'h8FFF},
			'{32'h0100_0000, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0400, 16'h8FFF},
			'{32'h0100_0005, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0800, 16'h8FFF},
			'{32'h0100_0006, 16'h0100, 16'h0000, 8'h33, 16'h0101, 8'h33, 16'h0000, 16'h8FFF}};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		checkWord("reset outputs", 32'h0, {28'h0, stopMode, irqEnable, bankSel});
		wbCycle(1'b0, ADDR_MASK, 32'h0, rd);
		checkWord("mask reset", 32'h0000_000F, rd & 32'h0000_000F);
		wbCycle(1'b0, ADDR_STAT, 32'h0, rd);
		checkWord("stat reset", 32'h0, rd);
		wbCycle(1'b1, 8'h1C, 32'hFFFF_FFFF, rd);
		wbCycle(1'b0, 8'h1C, 32'h0, rd);
		checkWord("unmapped read", 32'h0, rd);
		wbCycle(1'b1, ADDR_STAT, 32'hFFFF_FFFF, rd);
		wbCycle(1'b0, ADDR_STAT, 32'h0, rd);
		checkWord("stat after write", 32'h0, rd);
		foreach (rows[i]) begin
			wbCycle(1'b1, ADDR_PC, {16'h0, rows[i].pc0}, rd);
			wbCycle(1'b1, ADDR_DISP, {16'h0, rows[i].disp}, rd);
			wbCycle(1'b1, ADDR_DST, {24'h0, rows[i].dst0}, rd);
			wbCycle(1'b1, ADDR_PSW, 32'h0000_0051, rd);
			execInstr(rows[i].instr);
			wbCycle(1'b0, ADDR_PC, 32'h0, rd);
			checkWord("pc", {16'h0, rows[i].expPc}, rd & 32'h0000_FFFF);
			wbCycle(1'b0, ADDR_DST, 32'h0, rd);
			checkWord("dst", {24'h0, rows[i].expDst}, rd & 32'h0000_00FF);
			wbCycle(1'b0, ADDR_PSW, 32'h0, rd);
			checkWord("psw", 32'h0000_0051, rd & 32'h0000_00FF);
			wbCycle(1'b0, ADDR_STAT, 32'h0, rd);
			checkWord("stat", {16'h0, rows[i].expStat & rows[i].statMask},
				rd & {16'h0, rows[i].statMask});
			checkWord("core outputs", {28'h0, rows[i].expStat[15], rows[i].expStat[10],
				rows[i].expStat[9:8]}, {28'h0, stopMode, irqEnable, bankSel});
		end
		// Source 1 and source 2 request together; source 2 stays masked.
		wbCycle(1'b1, ADDR_MASK, 32'h0000_0004, rd);
		irqReq <= 4'b0110;
		noAck(10);
		execInstr(32'h0100_0004);
		noAck(10);
		ackBase = ackCount;
		execInstr(32'h0100_0000);
		waitAck(ackBase, 5'b00010);
		@(posedge clk);
		irqReq <= 4'b0100;
		noAck(10);
		execInstr(32'h0100_0005);
		msReq <= 1'b1;
		noAck(10);
		ackBase = ackCount;
		execInstr(32'h0100_0000);
		waitAck(ackBase, 5'b10000);
		@(posedge clk);
		msReq <= 1'b0;
		irqReq <= 4'h0;
		noAck(6);
		summarize();
	end
endmodule // lcce_top_tb
`default_nettype wire
